/* File: conv_pkg.sv */
// Package of register map, field positions and timing for the converter control block
// How it works
// [RULE1] Codes 001000-001111: gained pairs on inputs 0-3
// [RULE2] Codes 010000-010111: inputs 0-7 against input 1
// [RULE3] Codes 011000-011101: inputs 0-5 against input 2
// [RULE4] Code 011110 bandgap, 011111 ground
// [RULE5] Codes 100000-100111: single-ended inputs 8-15
// [RULE6] Codes 101000-101111: gained pairs on inputs 8-11
// [RULE7] Codes 110000-110111: inputs 8-15 against input 9
// [RULE8] Codes 111000-111101: inputs 8-13 against input 10
// [RULE9] Software never writes codes 111110 or 111111
// [RULE10] Control register index 0x7A, resets zero
// [RULE11] Enable bit powers converter up or down
// [RULE12] Clearing enable aborts a running conversion
// [RULE13] Single mode: each start launches one conversion
// [RULE14] Free-running: one start, conversions then continue
// [RULE15] First conversion after enable takes 25 cycles
// [RULE16] Start bit reads one while converting
// [RULE17] Writing zero to start is ignored
// [RULE18] Select msb from register B bit 3
// [RULE19] Select changes apply after current conversion
// [RULE20] Done flag set on completion, write-one clears
// [RULE21] Start ignored while converter is disabled
package conv_pkg;
	localparam logic [7:0]  IDX_CTRL_B    = 8'h7B;
	localparam logic [7:0]  IDX_CTRL_A    = 8'h7A;
	localparam logic [7:0]  IDX_MUX       = 8'h7C;
	localparam logic [7:0]  IDX_RESULT    = 8'h78;
	localparam logic [7:0]  IDX_STATUS    = 8'h80;
	localparam logic [31:0] ADDR_CTRL_B   = {22'h000000, IDX_CTRL_B, 2'b00};
	localparam logic [31:0] ADDR_CTRL_A   = {22'h000000, IDX_CTRL_A, 2'b00};
	localparam logic [31:0] ADDR_MUX      = {22'h000000, IDX_MUX, 2'b00};
	localparam logic [31:0] ADDR_RESULT   = {22'h000000, IDX_RESULT, 2'b00};
	localparam logic [31:0] ADDR_STATUS   = {22'h000000, IDX_STATUS, 2'b00};
	localparam int          EN_BIT        = 7;
	localparam int          START_BIT     = 6;
	localparam int          ATE_BIT       = 5;
	localparam int          FLAG_BIT      = 4;
	localparam int          MSB_BIT       = 3;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [2:0]  TRIG_FREE     = 3'h0;
	localparam logic [5:0]  FIRST_CYCLES  = 6'h19;
	localparam logic [5:0]  NORM_CYCLES   = 6'h0D;
	localparam logic [1:0]  GAIN_1        = 2'h0;
	localparam logic [1:0]  GAIN_10       = 2'h1;
	localparam logic [1:0]  GAIN_200      = 2'h2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef enum logic [2:0] {
		SRC_SINGLE,
		SRC_DIFF,
		SRC_BANDGAP,
		SRC_GROUND,
		SRC_RESERVED
	} src_kind_t;
endpackage : conv_pkg

/* File: channel_decode.sv */
// Decoder from the 6-bit select code to input routing and gain
`timescale 1ns/100ps
`default_nettype none
module channel_decode
	import conv_pkg::*;
(
	input  wire logic [5:0] code,
	output src_kind_t       kind,
	output logic [3:0]      pos_input,
	output logic [3:0]      neg_input,
	output logic [1:0]      gain
);
	// Decode by code group
	always_comb
	begin
		kind      = SRC_DIFF;
		pos_input = 4'h0;
		neg_input = 4'h0;
		gain      = GAIN_1;
		case (code[5:3])
			3'h0:
			begin
				kind      = SRC_SINGLE;
				pos_input = {1'b0, code[2:0]};
			end
			3'h1, 3'h5:
			begin
				pos_input = {code[5], 1'b0, code[2], code[0]}; // [RULE1] [RULE6]
				neg_input = {code[5], 1'b0, code[2], 1'b0};
				gain      = code[1] ? GAIN_200 : GAIN_10;
			end
			3'h2:
			begin
				pos_input = {1'b0, code[2:0]}; // [RULE2]
				neg_input = 4'h1;
			end
			3'h3:
			begin
				if (code[2:1] == 2'h3)
				begin
					kind = code[0] ? SRC_GROUND : SRC_BANDGAP; // [RULE4]
				end
				else
				begin
					pos_input = {1'b0, code[2:0]}; // [RULE3]
					neg_input = 4'h2;
				end
			end
			3'h4:
			begin
				kind      = SRC_SINGLE;
				pos_input = {1'b1, code[2:0]}; // [RULE5]
			end
			3'h6:
			begin
				pos_input = {1'b1, code[2:0]}; // [RULE7]
				neg_input = 4'h9;
			end
			3'h7:
			begin
				if (code[2:1] == 2'h3)
				begin
					kind = SRC_RESERVED; // [RULE9]
				end
				else
				begin
					pos_input = {1'b1, code[2:0]}; // [RULE8]
					neg_input = 4'hA;
				end
			end
			default:
			begin
				kind = SRC_RESERVED;
			end
		endcase
	end
endmodule : channel_decode
`default_nettype wire

/* File: conv_sequencer.sv */
// Conversion timer counting converter clock enables
`timescale 1ns/100ps
`default_nettype none
module conv_sequencer
	import conv_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       tick,
	input  wire logic       launch,
	input  wire logic       first,
	input  wire logic       abort,
	output logic            busy,
	output logic            done
);
	logic [5:0] left_r;
	// Count down the cycle budget of one conversion
	always_ff @(posedge aclk)
	begin
		if (!aresetn || abort)
		begin
			left_r <= 6'h00; // [RULE12]
			busy   <= 1'b0;
			done   <= 1'b0;
		end
		else if (launch)
		begin
			left_r <= first ? FIRST_CYCLES : NORM_CYCLES; // [RULE15]
			busy   <= 1'b1;
			done   <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (busy && tick)
			begin
				left_r <= left_r - 6'h01;
				if (left_r == 6'h01)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : conv_sequencer
`default_nettype wire

/* File: adc_channel_mux_and_control.sv */
// Top of the converter control block with its AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module adc_channel_mux_and_control
	import conv_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [9:0]  conv_result,
	output logic             converter_enable,
	output logic             sample_active,
	output src_kind_t        active_kind,
	output logic [3:0]       active_pos,
	output logic [3:0]       active_neg,
	output logic [1:0]       active_gain,
	output logic [5:0]       input_channel_select
);
	import conv_pkg::*;

	logic [7:0]  ctrl_a_r;
	logic [7:0]  ctrl_b_r;
	logic [7:0]  mux_r;
	logic [9:0]  result_r;
	logic [5:0]  active_code_r;
	logic        first_pending_r;
	logic [6:0]  prescale_r;
	logic        tick;
	logic        busy;
	logic        done;
	logic        launch;
	logic        abort;
	logic        aw_held_r;
	logic        w_held_r;
	logic [31:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        wr_fire;
	logic        wr_ok;
	logic        hit_ctrl_a;
	logic        hit_ctrl_b;
	logic        hit_mux;
	logic [7:0]  wbyte;
	logic        start_write;
	logic        free_run;
	logic [5:0]  code_now;
	logic [6:0]  div_mask;
	src_kind_t   dec_kind;
	logic [3:0]  dec_pos;
	logic [3:0]  dec_neg;
	logic [1:0]  dec_gain;

	// Write channel capture; address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 32'h00000000;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
		end
		else if (wr_fire)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
		end
	end

	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wbyte         = wdata_r[7:0];
	assign wr_ok         = wr_fire && wstrb_r[0];

	// Register hits of the captured write address; one word per register
	// Only byte lane 0 carries data, the upper lanes are ignored
	assign hit_ctrl_a = awaddr_r == ADDR_CTRL_A;
	assign hit_ctrl_b = awaddr_r == ADDR_CTRL_B;
	assign hit_mux    = awaddr_r == ADDR_MUX;

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (hit_ctrl_a || hit_ctrl_b || hit_mux) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Start, abort and relaunch conditions
	// A zero in the start bit never reaches the timer, so it cannot stop it
	assign start_write = wr_ok && hit_ctrl_a && wbyte[START_BIT]; // [RULE17]
	assign free_run    = ctrl_a_r[ATE_BIT] && ctrl_b_r[2:0] == TRIG_FREE;
	assign abort       = busy && !ctrl_a_r[EN_BIT]; // [RULE12]
	assign launch      = (start_write && wbyte[EN_BIT] && !busy) || // [RULE13] [RULE21]
		(done && free_run && ctrl_a_r[EN_BIT]); // [RULE14]

	// Control register A
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_a_r <= CTRL_RESET; // [RULE10]
		end
		else
		begin
			// Start bit is never stored; reads show the running conversion instead
			if (wr_ok && hit_ctrl_a)
			begin
				ctrl_a_r[EN_BIT]  <= wbyte[EN_BIT]; // [RULE11]
				ctrl_a_r[ATE_BIT] <= wbyte[ATE_BIT];
				ctrl_a_r[3:0]     <= wbyte[3:0];
				if (wbyte[FLAG_BIT])
				begin
					ctrl_a_r[FLAG_BIT] <= 1'b0; // [RULE20]
				end
			end
			if (done)
			begin
				ctrl_a_r[FLAG_BIT] <= 1'b1; // [RULE20]
			end
			ctrl_a_r[START_BIT] <= 1'b0;
		end
	end

	// Register B and multiplexer register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_b_r <= CTRL_RESET;
			mux_r    <= CTRL_RESET;
		end
		else if (wr_ok)
		begin
			if (hit_ctrl_b)
			begin
				ctrl_b_r <= {1'b0, wbyte[6], 2'b00, wbyte[3:0]};
			end
			if (hit_mux)
			begin
				mux_r <= wbyte;
			end
		end
	end

	assign code_now = {ctrl_b_r[MSB_BIT], mux_r[4:0]}; // [RULE18]

	// First-conversion marker, armed while disabled
	// A start written together with the enable still counts as the first
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			first_pending_r <= 1'b1;
		end
		else if (!ctrl_a_r[EN_BIT] && !(start_write && wbyte[EN_BIT]))
		begin
			first_pending_r <= 1'b1;
		end
		else if (launch)
		begin
			first_pending_r <= 1'b0; // [RULE15]
		end
	end

	// Latch the select code at launch, result at completion
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			active_code_r <= 6'h00;
			result_r      <= 10'h000;
		end
		else
		begin
			if (launch)
			begin
				active_code_r <= code_now; // [RULE19]
			end
			if (done)
			begin
				result_r <= conv_result;
			end
		end
	end

	// Converter clock divider from the three select bits
	always_comb
	begin
		case (ctrl_a_r[2:0])
			3'h0, 3'h1: div_mask = 7'h01;
			3'h2:       div_mask = 7'h03;
			3'h3:       div_mask = 7'h07;
			3'h4:       div_mask = 7'h0F;
			3'h5:       div_mask = 7'h1F;
			3'h6:       div_mask = 7'h3F;
			default:    div_mask = 7'h7F;
		endcase
	end

	// Prescaler restarts at each launch so every conversion sees whole periods
	always_ff @(posedge aclk)
	begin
		if (!aresetn || launch)
		begin
			prescale_r <= 7'h00;
		end
		else
		begin
			prescale_r <= prescale_r + 7'h01;
		end
	end

	assign tick = (prescale_r & div_mask) == div_mask;

	// Conversion timer
	conv_sequencer u_seq (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick),
		.launch  (launch),
		.first   (first_pending_r),
		.abort   (abort),
		.busy    (busy),
		.done    (done)
	);

	// Routing follows the code latched at launch, not the live registers
	channel_decode u_dec (
		.code      (active_code_r),
		.kind      (dec_kind),
		.pos_input (dec_pos),
		.neg_input (dec_neg),
		.gain      (dec_gain)
	);

	// Registered routing outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			active_kind <= SRC_SINGLE;
			active_pos  <= 4'h0;
			active_neg  <= 4'h0;
			active_gain <= GAIN_1;
		end
		else
		begin
			active_kind <= dec_kind;
			active_pos  <= dec_pos;
			active_neg  <= dec_neg;
			active_gain <= dec_gain;
		end
	end

	assign converter_enable     = ctrl_a_r[EN_BIT];
	assign sample_active        = busy;
	assign input_channel_select = active_code_r;

	// Read channel
	// Only one read is accepted until its data has been taken
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CTRL_A: s_axi_rdata <= {24'h000000, ctrl_a_r[7],
					busy, ctrl_a_r[5:0]}; // [RULE16]
				ADDR_CTRL_B: s_axi_rdata <= {24'h000000, ctrl_b_r};
				ADDR_MUX:    s_axi_rdata <= {24'h000000, mux_r};
				ADDR_RESULT: s_axi_rdata <= {22'h000000, result_r};
				ADDR_STATUS: s_axi_rdata <= {26'h0000000, active_code_r};
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : adc_channel_mux_and_control
`default_nettype wire

/* File: conv_checker.sv */
// Port-level assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
module conv_checker
(
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic                s_axi_arready,
	input wire logic                s_axi_rvalid,
	input wire logic                converter_enable,
	input wire logic                sample_active,
	input wire conv_pkg::src_kind_t active_kind,
	input wire logic [3:0]          active_pos,
	input wire logic [3:0]          active_neg,
	input wire logic [1:0]          active_gain,
	input wire logic [5:0]          input_channel_select
);
	import conv_pkg::*;
	logic [11:0] run_len_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Length of the conversion now running
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !sample_active)
			run_len_r <= 12'h000;
		else
			run_len_r <= run_len_r + 12'h001;
	end
	// Select code unchanged since the last edge
	sequence s_sel_held;
		$stable(input_channel_select);
	endsequence
	property p_start_en;
		$rose(sample_active) |-> converter_enable;
	endproperty
	property p_abort;
		$fell(converter_enable) |-> ##[0:1] !sample_active;
	endproperty
	property p_sel_freeze;
		$past(sample_active) && sample_active |-> $stable(input_channel_select);
	endproperty
	property p_len;
		$fell(sample_active) && converter_enable |-> run_len_r >= 12'h018 && run_len_r <= 12'hC90;
	endproperty
	property p_pair_gain;
		active_kind == SRC_DIFF && active_gain != GAIN_1
			|-> active_neg == {active_pos[3:1], 1'b0} && !active_pos[2];
	endproperty
	property p_code2;
		(input_channel_select[5:3] == 3'h2) ##0 s_sel_held |-> active_kind == SRC_DIFF
			&& active_neg == 4'h1 && active_pos == {1'b0, input_channel_select[2:0]};
	endproperty
	property p_bandgap;
		(input_channel_select == 6'h1E) ##0 s_sel_held |-> active_kind == SRC_BANDGAP;
	endproperty
	property p_single_hi;
		(input_channel_select[5:3] == 3'h4) ##0 s_sel_held |-> active_kind == SRC_SINGLE
			&& active_pos == {1'b1, input_channel_select[2:0]};
	endproperty
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_start_en: assert property (p_start_en)
		else $error("start while off");
	a_abort: assert property (p_abort)
		else $error("no abort");
	a_sel_freeze: assert property (p_sel_freeze)
		else $error("select moved");
	a_len: assert property (p_len)
		else $error("bad length");
	a_pair_gain: assert property (p_pair_gain)
		else $error("bad gained pair");
	a_code2: assert property (p_code2)
		else $error("bad input 1 pair");
	a_bandgap: assert property (p_bandgap)
		else $error("no bandgap");
	a_single_hi: assert property (p_single_hi)
		else $error("bad upper single");
	a_ar_block: assert property (p_ar_block)
		else $error("read overlap");
endmodule : conv_checker

bind adc_channel_mux_and_control conv_checker u_conv_checker (.aclk, .aresetn, .s_axi_arready,
	.s_axi_rvalid, .converter_enable, .sample_active, .active_kind, .active_pos, .active_neg,
	.active_gain, .input_channel_select);
`default_nettype wire

/* File: conv_core_model.sv */
// Behavioural converter core giving a result per conversion
`timescale 1ns/100ps
`default_nettype none
module conv_core_model
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       sample_active,
	input wire logic [5:0] input_channel_select,
	output logic [9:0]     conv_result
);
	logic hold_r;
	// Result valid during and one cycle after a conversion, scrambled otherwise
	always_ff @(posedge aclk)
	begin
		hold_r <= sample_active;
		if (!aresetn)
			conv_result <= 10'h2AA;
		else if (sample_active)
			conv_result <= {4'h5, input_channel_select};
		else if (!hold_r)
			conv_result <= ~conv_result;
	end
endmodule : conv_core_model
`default_nettype wire

/* File: tb_top.sv */
// Register-level testbench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import conv_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, active_gain, rd_resp, wr_resp;
	logic [31:0] s_axi_rdata, rd_data;
	logic [9:0]  conv_result;
	logic        converter_enable, sample_active, act_d = 1'b0;
	src_kind_t   active_kind;
	logic [3:0]  active_pos, active_neg;
	logic [5:0]  input_channel_select;
	logic [11:0] run_n = 12'h000, last_len = 12'h000;
	logic [12:0] e;
	int          bad_count = 0, checks_done = 0, i;

	always #5 aclk = ~aclk;

	adc_channel_mux_and_control u_adc_channel_mux_and_control (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_result, .converter_enable,
		.sample_active, .active_kind, .active_pos, .active_neg, .active_gain, .input_channel_select);
	conv_core_model u_conv_core_model (.aclk, .aresetn, .sample_active, .input_channel_select,
		.conv_result);

	// Length of the last finished conversion in clock cycles
	always @(posedge aclk)
	begin
		act_d <= sample_active;
		run_n <= sample_active ? run_n + 12'h001 : 12'h000;
		if (act_d && !sample_active)
			last_len <= run_n;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic aw_p, w_p;
		@(posedge aclk);
		aw_p = 1'b1;
		w_p = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			aw_p = aw_p && !s_axi_awready;
			w_p = w_p && !s_axi_wready;
			s_axi_awvalid <= aw_p;
			s_axi_wvalid <= w_p;
		end while (!s_axi_bvalid);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a);
		logic ar_p;
		@(posedge aclk);
		ar_p = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			ar_p = ar_p && !s_axi_arready;
			s_axi_arvalid <= ar_p;
		end while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Set select code, then write control A
	task automatic conv(input logic [5:0] c, input logic [7:0] a);
		wr(ADDR_CTRL_B, {4'h0, c[5], 3'h0});
		wr(ADDR_MUX, {3'h0, c[4:0]});
		wr(ADDR_CTRL_A, a);
	endtask : conv

	task automatic wait_idle();
		int n;
		n = 0;
		while (sample_active && n < 4000)
		begin
			@(posedge aclk);
			n++;
		end
		repeat (2) @(posedge aclk);
	endtask : wait_idle

	// Expected kind, positive, negative and gain for a code
	function automatic logic [12:0] dec(input logic [5:0] c);
		case (c[5:3])
			3'h1, 3'h5: return {SRC_DIFF, c[5], 1'b0, c[2], c[0], c[5], 1'b0, c[2], 1'b0,
				c[1] ? GAIN_200 : GAIN_10};
			3'h2: return {SRC_DIFF, 1'b0, c[2:0], 4'h1, GAIN_1};
			3'h3: return (c[2:1] == 2'h3) ? {c[0] ? SRC_GROUND : SRC_BANDGAP, 10'h000}
				: {SRC_DIFF, 1'b0, c[2:0], 4'h2, GAIN_1};
			3'h4: return {SRC_SINGLE, 1'b1, c[2:0], 6'h00};
			3'h6: return {SRC_DIFF, 1'b1, c[2:0], 4'h9, GAIN_1};
			default: return {SRC_DIFF, 1'b1, c[2:0], 4'hA, GAIN_1};
		endcase
	endfunction : dec

	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	// Watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		$display("Error watchdog expected done seen hang");
		report_and_stop();
	end

	// Main sequence; reserved codes 62 and 63 are never written
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_CTRL_A);
		chk("ctrl_a_reset", 32'h0, rd_data);
		rd(32'h00000084);
		chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rd_resp});
		wr(32'h00000084, 8'h00);
		chk("unmapped_wresp", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
		wr(ADDR_CTRL_A, 8'h40);
		chk("wr_okay", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
		repeat (5) @(posedge aclk);
		chk("start_off", 32'h0, sample_active);
		for (i = 8; i < 62; i++)
		begin
			conv(i[5:0], 8'hD0);
			if (i == 8)
			begin
				rd(ADDR_CTRL_A);
				chk("busy_read", 32'hC0, rd_data);
			end
			wait_idle();
			chk("len", 32'h1, last_len >= (i == 8 ? 12'h02F : 12'h017)
				&& last_len <= (i == 8 ? 12'h035 : 12'h01D));
			e = dec(i[5:0]);
			chk("select", i, input_channel_select);
			chk("kind", e[12:10], active_kind);
			if (e[12:10] == SRC_SINGLE || e[12:10] == SRC_DIFF)
				chk("pos", e[9:6], active_pos);
			if (e[12:10] == SRC_DIFF)
			begin
				chk("neg", e[5:2], active_neg);
				chk("gain", e[1:0], active_gain);
			end
		end
		rd(ADDR_CTRL_A);
		chk("flag_set", 32'h90, rd_data);
		rd(ADDR_RESULT);
		chk("result", 32'h17D, rd_data);
		repeat (40) @(posedge aclk);
		chk("single_once", 32'h0, sample_active);
		wr(ADDR_CTRL_A, 8'h90);
		rd(ADDR_CTRL_A);
		chk("flag_clear", 32'h80, rd_data);
		conv(6'h30, 8'hC0);
		wr(ADDR_MUX, 8'h05);
		chk("sel_held", 32'h30, input_channel_select);
		wr(ADDR_CTRL_A, 8'h80);
		chk("zero_start", 32'h1, sample_active);
		wait_idle();
		rd(ADDR_CTRL_A);
		chk("zero_start_done", 32'h90, rd_data);
		wr(ADDR_CTRL_A, 8'hD0);
		chk("sel_new", 32'h25, input_channel_select);
		wr(ADDR_CTRL_A, 8'h00);
		@(posedge aclk);
		chk("abort", 32'h0, sample_active);
		chk("enable_off", 32'h0, converter_enable);
		rd(ADDR_CTRL_A);
		chk("abort_no_flag", 32'h0, rd_data);
		wr(ADDR_CTRL_A, 8'hC0);
		chk("enable_on", 32'h1, converter_enable);
		wait_idle();
		chk("first_len", 32'h1, last_len >= 12'h02F && last_len <= 12'h035);
		wr(ADDR_CTRL_A, 8'hF0);
		wait_idle();
		chk("free_run", 32'h1, sample_active);
		wait_idle();
		chk("free_len", 32'h1, last_len >= 12'h017 && last_len <= 12'h01D);
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_CTRL_A, 8'hC2);
		wait_idle();
		chk("div4_len", 32'h1, last_len >= 12'h061 && last_len <= 12'h067);
		wr(ADDR_CTRL_A, 8'h00);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
